// File: src/asb_map.svh
// timing and geometry constants for the async byte-wide memory controller
`ifndef ASB_MAP_SVH
`define ASB_MAP_SVH
`define ASB_CLK_PERIOD_NS 20
`define ASB_ADDR_W 17
`define ASB_DATA_W 8
// slow grade figures, the stricter of the two
`define ASB_CYCLE_MIN_NS 10
`define ASB_ACCESS_MAX_NS 10
`define ASB_STROBE_PULSE_MIN_OUTPUTS_ON_NS 10
`define ASB_DATA_SETUP_NS 5
`define ASB_DATA_HOLD_AFTER_CLOSE_NS 0
`define ASB_BUS_TURN_NS 5
// least times round up to whole cycles, never under one
`define ASB_CYC_UP(t) ((((t) + `ASB_CLK_PERIOD_NS - 1) / `ASB_CLK_PERIOD_NS) < 1 ? 1 : \
   (((t) + `ASB_CLK_PERIOD_NS - 1) / `ASB_CLK_PERIOD_NS))
// read window asks for twice the access time, trading speed for margin
`define ASB_RD_CYC `ASB_CYC_UP(`ASB_ACCESS_MAX_NS + `ASB_ACCESS_MAX_NS)
`define ASB_WR_CYC `ASB_CYC_UP(`ASB_STROBE_PULSE_MIN_OUTPUTS_ON_NS)
`define ASB_TURN_CYC `ASB_CYC_UP(`ASB_BUS_TURN_NS)
`define ASB_CNT_W 4
`endif

// File: src/asb_pkg.sv
// types for the async byte-wide memory controller
`default_nettype none
package asb_pkg;
   // one bit flips per step, except close to turn: the write loop has odd length
   typedef enum logic [2:0] {
      ASB_IDLE   = 3'h0,
      ASB_SETUP  = 3'h1,
      ASB_STROBE = 3'h3,
      ASB_CLOSE  = 3'h7,
      ASB_READ   = 3'h5,
      ASB_TURN   = 3'h4
   } asb_state_t;
endpackage
`default_nettype wire

// File: src/asb_ctrl.sv
// host controller driving an asynchronous byte-wide static memory
// How it works
// - store strobe stays high throughout every read.
// - select low at least 7 ns before the window closes.
// - address valid at least 7 ns before the window closes.
// - strobe low at least 7 ns when drive enable is high.
// - strobe low at least 10 ns when drive enable is low.
// - write data stable at least 5 ns before the window closes.
// - write data held until the window has closed.
// - address valid no later than the window opens.
// - address unchanged until the window has closed.
`timescale 1ns/1ps
`default_nettype none
`include "asb_map.svh"
module asb_ctrl (
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic                     clk_en,
   input  wire logic                     req_valid,
   input  wire logic                     req_write,
   input  wire logic [`ASB_ADDR_W-1:0]   req_addr,
   input  wire logic [`ASB_DATA_W-1:0]   req_wdata,
   output logic                          req_ready,
   output logic                          rsp_valid,
   output logic [`ASB_DATA_W-1:0]        rsp_rdata,
   output logic [`ASB_ADDR_W-1:0]        word_index_lines,
   output logic                          unit_select_n,
   output logic                          store_strobe_n,
   output logic                          drive_enable_n,
   input  wire logic [`ASB_DATA_W-1:0]   shared_byte_lines_i,
   output logic [`ASB_DATA_W-1:0]        shared_byte_lines_o,
   output logic                          shared_byte_lines_oe
);
   asb_pkg::asb_state_t state_q, state_d;
   logic [`ASB_CNT_W-1:0] cnt_q, cnt_d;
   logic                  write_q;

   // pacing counter expiry and request acceptance
   wire cnt_done  = (cnt_q == `ASB_CNT_W'(0));
   wire in_idle   = (state_q == asb_pkg::ASB_IDLE);
   wire take_req  = in_idle && req_valid;

   // present-state views read by the response logic
   wire in_close  = (state_q == asb_pkg::ASB_CLOSE);
   wire in_read   = (state_q == asb_pkg::ASB_READ);

   // counter reloads, one short because the load cycle itself counts
   wire [`ASB_CNT_W-1:0] wr_load   = `ASB_CNT_W'(`ASB_WR_CYC - 1);
   wire [`ASB_CNT_W-1:0] rd_load   = `ASB_CNT_W'(`ASB_RD_CYC - 1);
   wire [`ASB_CNT_W-1:0] turn_load = `ASB_CNT_W'(`ASB_TURN_CYC - 1);
   wire [`ASB_CNT_W-1:0] cnt_dec   = cnt_done ? cnt_q : cnt_q - `ASB_CNT_W'(1);

   // sequencer: next state and wait counts
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_dec;
      case (state_q)
         asb_pkg::ASB_IDLE: begin
            if (req_valid) begin
               state_d = asb_pkg::ASB_SETUP;
               cnt_d   = `ASB_CNT_W'(0);
            end
         end
         asb_pkg::ASB_SETUP: begin
            // address and select settle one cycle before any strobe
            state_d = write_q ? asb_pkg::ASB_STROBE : asb_pkg::ASB_READ;
            cnt_d   = write_q ? wr_load : rd_load;
         end
         asb_pkg::ASB_STROBE: begin
            if (cnt_done) begin
               state_d = asb_pkg::ASB_CLOSE;
            end
         end
         asb_pkg::ASB_CLOSE: begin
            state_d = asb_pkg::ASB_TURN;
            cnt_d   = turn_load;
         end
         asb_pkg::ASB_READ: begin
            if (cnt_done) begin
               state_d = asb_pkg::ASB_TURN;
               cnt_d   = turn_load;
            end
         end
         asb_pkg::ASB_TURN: begin
            if (cnt_done) begin
               state_d = asb_pkg::ASB_IDLE;
            end
         end
         default: begin
            state_d = asb_pkg::ASB_IDLE;
            cnt_d   = `ASB_CNT_W'(0);
         end
      endcase
   end

   // pin levels decoded from the next state so every pin leaves a flop
   wire sel_d    = (state_d != asb_pkg::ASB_IDLE) && (state_d != asb_pkg::ASB_TURN);
   // strobe low only inside the select window
   wire strobe_d = (state_d == asb_pkg::ASB_STROBE);
   // drive enable low only for reads
   wire drive_d  = (state_d == asb_pkg::ASB_READ);
   // drive the bus only on a write path, never while reading or turning
   wire oe_d     = (state_d == asb_pkg::ASB_SETUP && (take_req ? req_write : write_q)) ||
                   (state_d == asb_pkg::ASB_STROBE) || (state_d == asb_pkg::ASB_CLOSE);
   // capture read data at the end of the access window
   wire rd_cap   = in_read && cnt_done;

   // state and counter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q <= asb_pkg::ASB_IDLE;
         cnt_q   <= `ASB_CNT_W'(0);
      end else if (clk_en) begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // direction of the access in flight, steers the sequencer out of setup
   always_ff @(posedge core_clk) begin
      if (rst) begin
         write_q <= 1'b0;
      end else if (clk_en && take_req) begin
         write_q <= req_write;
      end
   end

   // address latched at acceptance, so valid before the window opens
   // it stays put until the next request, long after the window closes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         word_index_lines <= `ASB_ADDR_W'(0);
      end else if (clk_en && take_req) begin
         word_index_lines <= req_addr;
      end
   end

   // write byte latched at acceptance, a whole cycle ahead of the strobe
   // held until the next request, so it outlasts the window
   always_ff @(posedge core_clk) begin
      if (rst) begin
         shared_byte_lines_o <= `ASB_DATA_W'(0);
      end else if (clk_en && take_req) begin
         shared_byte_lines_o <= req_wdata;
      end
   end

   // select high whenever idle or turning
   // select falls a cycle before strobe; drive enable stays high, so the memory never drives during a write
   // select and address lead the window close by more than a cycle
   always_ff @(posedge core_clk) begin
      if (rst) begin
         unit_select_n <= 1'b1;
      end else if (clk_en) begin
         unit_select_n <= ~sel_d;
      end
   end

   // strobe held a whole cycle count of at least 10 ns
   always_ff @(posedge core_clk) begin
      if (rst) begin
         store_strobe_n <= 1'b1;
      end else if (clk_en) begin
         store_strobe_n <= ~strobe_d;
      end
   end

   // drive enable low only while reading; a freeze stretches it, never shortens it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         drive_enable_n <= 1'b1;
      end else if (clk_en) begin
         drive_enable_n <= ~drive_d;
      end
   end

   // data drive lasts one cycle past the strobe rise
   // bus off a full cycle before and after any read
   always_ff @(posedge core_clk) begin
      if (rst) begin
         shared_byte_lines_oe <= 1'b0;
      end else if (clk_en) begin
         shared_byte_lines_oe <= oe_d;
      end
   end

   // completion pulse: end of the read window, or the cycle after a write closes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
      end else if (clk_en) begin
         rsp_valid <= rd_cap || in_close;
      end
   end

   // sample after the full access time of the new address
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rsp_rdata <= `ASB_DATA_W'(0);
      end else if (clk_en && rd_cap) begin
         rsp_rdata <= shared_byte_lines_i;
      end
   end

   // ready is decoded from the next state, so it tracks the idle state in the same cycle and never leads acceptance
   always_ff @(posedge core_clk) begin
      if (rst) begin
         req_ready <= 1'b0;
      end else if (clk_en) begin
         req_ready <= (state_d == asb_pkg::ASB_IDLE);
      end
   end
endmodule
`default_nettype wire

// File: tb/asb_sram_model.sv
// behavioural byte-wide static memory on the far side of the pins
`timescale 1ns/1ps
`default_nettype none
module asb_sram_model (
   input  wire logic [16:0] word_index_lines,
   input  wire logic        unit_select_n,
   input  wire logic        store_strobe_n,
   input  wire logic        drive_enable_n,
   input  wire logic [7:0]  shared_byte_lines_o,
   input  wire logic        shared_byte_lines_oe,
   output logic [7:0]       shared_byte_lines_i
);
   logic [7:0] mem [0:131071];
   logic [7:0] rd_q;
   logic       drv_q;
   wire        rd_on;
   assign rd_on = !unit_select_n && store_strobe_n && !drive_enable_n;
   always @(rd_on) drv_q <= #3 rd_on;
   always @(word_index_lines, rd_on) rd_q <= #8 mem[word_index_lines];
   always @(posedge (unit_select_n | store_strobe_n)) mem[word_index_lines] <= shared_byte_lines_i;
   // an idle bus shows stale data inverted, so a late sample cannot pass by luck
   assign shared_byte_lines_i = shared_byte_lines_oe ? shared_byte_lines_o : drv_q ? rd_q : ~rd_q;
endmodule
`default_nettype wire

// File: tb/asb_ctrl_asserts.sv
// pin-level checks on the memory controller
`timescale 1ns/1ps
`default_nettype none
module asb_ctrl_asserts (
   input wire logic        core_clk,
   input wire logic        rst,
   input wire logic [16:0] word_index_lines,
   input wire logic        unit_select_n,
   input wire logic        store_strobe_n,
   input wire logic        drive_enable_n,
   input wire logic [7:0]  shared_byte_lines_o,
   input wire logic        shared_byte_lines_oe
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // strobe shape, bus ownership and pin stability around the window
   a_no_rd_strobe: assert property (!drive_enable_n |-> store_strobe_n) else $error("strobe in read");
   a_no_fight: assert property (shared_byte_lines_oe |-> drive_enable_n && $past(drive_enable_n))
      else $error("bus fight");
   a_sel_leads: assert property ($fell(store_strobe_n) |-> $past(unit_select_n) == 1'b0) else $error("sel late");
   a_pulse_len: assert property ($fell(store_strobe_n) |=> store_strobe_n ##1 unit_select_n) else $error("pulse");
   a_addr_setup: assert property ($fell(store_strobe_n) |-> $stable(word_index_lines)) else $error("addr setup");
   a_addr_hold: assert property ($rose(store_strobe_n) |-> $stable(word_index_lines)) else $error("addr hold");
   a_data_setup: assert property ($fell(store_strobe_n) |-> $stable(shared_byte_lines_o)) else $error("data");
   a_data_hold: assert property ($rose(store_strobe_n) |-> shared_byte_lines_oe) else $error("data hold");
   c_write: cover property ($fell(store_strobe_n));
   c_read: cover property ($fell(drive_enable_n));
   c_release: cover property ($rose(unit_select_n));
endmodule
bind asb_ctrl asb_ctrl_asserts u_asb_ctrl_asserts (
   .core_clk             (core_clk),
   .rst                  (rst),
   .word_index_lines     (word_index_lines),
   .unit_select_n        (unit_select_n),
   .store_strobe_n       (store_strobe_n),
   .drive_enable_n       (drive_enable_n),
   .shared_byte_lines_o  (shared_byte_lines_o),
   .shared_byte_lines_oe (shared_byte_lines_oe)
);
`default_nettype wire

// File: tb/async_sram_byte_port_tb.sv
// bench: controller plus memory model against a reference byte map
`timescale 1ns/1ps
`default_nettype none
`include "asb_map.svh"
module async_sram_byte_port_tb;
   logic        core_clk, rst, clk_en, req_valid, req_write, req_ready, rsp_valid;
   logic        unit_select_n, store_strobe_n, drive_enable_n, shared_byte_lines_oe;
   logic [16:0] req_addr, word_index_lines, rnd_addr;
   logic [7:0]  req_wdata, rsp_rdata, shared_byte_lines_i, shared_byte_lines_o;
   logic [31:0] seed;
   int          bad_count, cmp_count, cyc, lat, exp_lat;
   int          ref_mem [int];
   asb_ctrl u_asb_ctrl (
      .core_clk             (core_clk),
      .rst                  (rst),
      .clk_en               (clk_en),
      .req_valid            (req_valid),
      .req_write            (req_write),
      .req_addr             (req_addr),
      .req_wdata            (req_wdata),
      .req_ready            (req_ready),
      .rsp_valid            (rsp_valid),
      .rsp_rdata            (rsp_rdata),
      .word_index_lines     (word_index_lines),
      .unit_select_n        (unit_select_n),
      .store_strobe_n       (store_strobe_n),
      .drive_enable_n       (drive_enable_n),
      .shared_byte_lines_i  (shared_byte_lines_i),
      .shared_byte_lines_o  (shared_byte_lines_o),
      .shared_byte_lines_oe (shared_byte_lines_oe)
   );
   asb_sram_model u_asb_sram_model (
      .word_index_lines     (word_index_lines),
      .unit_select_n        (unit_select_n),
      .store_strobe_n       (store_strobe_n),
      .drive_enable_n       (drive_enable_n),
      .shared_byte_lines_o  (shared_byte_lines_o),
      .shared_byte_lines_oe (shared_byte_lines_oe),
      .shared_byte_lines_i  (shared_byte_lines_i)
   );
   // 50 MHz clock and a cycle ceiling against hangs
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         wrap_up();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      return s ^ (s << 5);
   endfunction
   task automatic wrap_up();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // request offered once idle, optional enable stall, then latency and data checked
   task automatic xfer(input logic w, input logic [16:0] a, input logic [7:0] d, input int frz);
      while (req_ready !== 1'b1) @(posedge core_clk) #2;
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_valid = 1'b1;
      @(posedge core_clk) #2;
      req_valid = 1'b0;
      // freeze the sequencer for frz edges right after acceptance
      if (frz > 0) begin
         clk_en = 1'b0;
         repeat (frz) @(posedge core_clk) #2;
         clk_en = 1'b1;
      end
      lat = frz;
      // setup, window, then the close cycle on writes only
      exp_lat = (w ? `ASB_WR_CYC + 2 : `ASB_RD_CYC + 1) + frz;
      do begin
         @(posedge core_clk) #2;
         lat++;
      end while (rsp_valid !== 1'b1 && lat < 20);
      cmp_count += w ? 1 : 2;
      if (lat != exp_lat) begin
         bad_count++;
         $display("unexpected latency: expected %0d seen %0d", exp_lat, lat);
      end
      if (w) ref_mem[a] = d;
      else if (rsp_rdata !== 8'(ref_mem[a])) begin
         bad_count++;
         $display("unexpected read byte: expected %0h seen %0h", ref_mem[a], rsp_rdata);
      end
   endtask
   // reset, end addresses with stalls, then random traffic on a small pool
   initial begin
      rst = 1'b1;
      clk_en = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 17'h0;
      req_wdata = 8'h0;
      seed = 32'h59;
      repeat (10) @(posedge core_clk);
      #2 rst = 1'b0;
      xfer(1'b1, 17'h0, 8'ha5, 0);
      xfer(1'b1, 17'h1ffff, 8'h5a, 2);
      xfer(1'b0, 17'h0, 8'h0, 0);
      xfer(1'b0, 17'h1ffff, 8'h0, 2);
      for (int i = 0; i < 200; i++) begin
         seed = xs(seed);
         rnd_addr = {seed[16:15], 11'h0, seed[3:0]};
         xfer(seed[8] | !ref_mem.exists(rnd_addr), rnd_addr, seed[31:24], 0);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
